// ### verilog/printer_port_pkg.sv
/*
  Constants and types shared by the printer port and its write buffer.
  Assumes a single 200 MHz system clock and host strobes synchronous to it.
*/
// Operation
// R1 - pin low: input only when select holds AA
// R2 - pin high: control bit 5 picks direction
// R3 - output mode: data port write drives pins
// R4 - input mode: data port read returns pins
// R5 - reset leaves data port in output mode
// R6 - acknowledge falling edge clears status bit 2
// R7 - status read sets status bit 2 again
// R8 - status bits 3-6 mirror four inputs
// R9 - status bit 7 is inverted busy
// R10 - status bits 1 and 0 read one
// R11 - command readback shows pins, enable, ones
// R12 - command bits active for low pins, init high
// R13 - control write drives the four handshake pins
// R14 - control bit 4 enables interrupt, 7-6 ignored
// R15 - two address bits select the registers
// R16 - reset: data output zero, strobe high, irq off
// R17 - irq driven while pending and enabled
// R18 - host reads status after each acknowledge
package printer_port_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [1:0] addr_t;

  // =========================================================
  // register selection
  localparam addr_t ADDR_DATA_PORT = 2'h0;
  localparam addr_t ADDR_SELECT_STATUS = 2'h1;
  localparam addr_t ADDR_CONTROL_COMMAND = 2'h2;

  // =========================================================
  // control register fields
  localparam int CTRL_STROBE = 0;
  localparam int CTRL_AUTO_LINEFEED = 1;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_SELECT_IN = 3;
  localparam int CTRL_IRQ_ENABLE = 4;
  localparam int CTRL_DIRECTION = 5;
  localparam int CTRL_WIDTH = 6;

  // =========================================================
  // status register fields
  localparam int STAT_IRQ_CLEAR = 2;
  localparam int STAT_ERROR = 3;
  localparam int STAT_SELECTED = 4;
  localparam int STAT_PAPER_EMPTY = 5;
  localparam int STAT_ACK = 6;
  localparam int STAT_NOT_BUSY = 7;

  // =========================================================
  // fixed values and reset values
  localparam byte_t INPUT_SELECT_CODE = 8'hAA;
  localparam logic [1:0] STATUS_LOW_ONES = 2'h3;
  localparam logic [2:0] COMMAND_HIGH_ONES = 3'h7;
  localparam byte_t DATA_RESET = 8'h00;
  localparam byte_t SELECT_RESET = 8'h00;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] RESET_SYNC_RESET = 2'h0;

  // =========================================================
  // write buffer shape
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;

endpackage

// ### verilog/word_buffer.sv
/*
  Two-entry flip-flop buffer with valid/ready on both sides.
  Assumes an asynchronous active-low reset already released cleanly.
*/
module word_buffer #(
  parameter int WIDTH = printer_port_pkg::BUF_WIDTH,
  parameter int DEPTH = printer_port_pkg::BUF_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import printer_port_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign in_ready_out = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage carries no reset: nothing reads an entry before it is written
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule

// ### verilog/printer_port.sv
/*
  Bidirectional printer port: data port, direction select, status,
  control and command readback, acknowledge interrupt, and a two-entry
  buffer between host data writes and the data pins.
  Assumes host strobes and printer inputs are synchronous to CLK_IN.
*/
module printer_port (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire printer_port_pkg::addr_t ADDR_IN,
  input wire logic WR_N_IN,
  input wire logic RD_N_IN,
  input wire printer_port_pkg::byte_t DATA_IN,
  output printer_port_pkg::byte_t DATA_OUT,
  output logic DATA_OE_OUT,
  output logic WRITE_READY_OUT,
  input wire logic DIRECTION_MODE_PIN_IN,
  input wire printer_port_pkg::byte_t PRINTER_DATA_PINS_IN,
  output printer_port_pkg::byte_t PRINTER_DATA_PINS_OUT,
  output logic PRINTER_DATA_PINS_OE_OUT,
  output logic STROBE_N_OUT,
  output logic AUTO_LINEFEED_N_OUT,
  output logic INIT_OUT,
  output logic SELECT_IN_N_OUT,
  input wire logic ERROR_N_IN,
  input wire logic PRINTER_SELECTED_IN,
  input wire logic PAPER_EMPTY_IN,
  input wire logic ACK_N_IN,
  input wire logic BUSY_IN,
  output logic PRINTER_IRQ_OUT,
  output logic PRINTER_IRQ_OE_OUT
);
  import printer_port_pkg::*;

  // =========================================================
  // reset release
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_sync <= RESET_SYNC_RESET;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!rst_n);

  // =========================================================
  // host strobe edges
  logic wr_n_q, rd_n_q;
  addr_t rd_addr;
  logic next_wr_n_q, next_rd_n_q;
  addr_t next_rd_addr;
  logic write_pulse, read_end;

  // writes act on the falling write strobe, read side effects on the
  // rising read strobe, so a long read cycle clears the flag only once
  assign write_pulse = wr_n_q & ~WR_N_IN;
  assign read_end = ~rd_n_q & RD_N_IN;

  always_comb
  begin
    next_wr_n_q = WR_N_IN;
    next_rd_n_q = RD_N_IN;
    next_rd_addr = RD_N_IN ? rd_addr : ADDR_IN;
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      rd_addr <= ADDR_DATA_PORT;
    end
    else
    begin
      wr_n_q <= next_wr_n_q;
      rd_n_q <= next_rd_n_q;
      rd_addr <= next_rd_addr;
    end
  end

  // =========================================================
  // control and direction select registers
  logic [CTRL_WIDTH-1:0] ctrl, next_ctrl;
  byte_t io_select, next_io_select;
  logic input_mode;

  always_comb
  begin
    next_ctrl = ctrl;
    next_io_select = io_select;
    if (write_pulse && ADDR_IN == ADDR_CONTROL_COMMAND) // R15
    begin
      next_ctrl = DATA_IN[CTRL_WIDTH-1:0]; // R14
    end
    if (write_pulse && ADDR_IN == ADDR_SELECT_STATUS) // R15
    begin
      next_io_select = DATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CTRL_RESET; // R16
      io_select <= SELECT_RESET; // R5
    end
    else
    begin
      ctrl <= next_ctrl;
      io_select <= next_io_select;
    end
  end

  always_comb
  begin
    if (DIRECTION_MODE_PIN_IN)
    begin
      input_mode = ctrl[CTRL_DIRECTION]; // R2
    end
    else
    begin
      input_mode = (io_select == INPUT_SELECT_CODE); // R1
    end
  end

  assign PRINTER_DATA_PINS_OE_OUT = ~input_mode; // R5
  assign STROBE_N_OUT = ~ctrl[CTRL_STROBE]; // R13
  assign AUTO_LINEFEED_N_OUT = ~ctrl[CTRL_AUTO_LINEFEED]; // R13
  assign INIT_OUT = ctrl[CTRL_INIT]; // R13
  assign SELECT_IN_N_OUT = ~ctrl[CTRL_SELECT_IN]; // R13

  // =========================================================
  // data write path
  // words written while the pins face inward wait here until output
  // mode returns; a third such write is refused and WRITE_READY_OUT shows it
  logic buf_in_valid, buf_out_valid;
  byte_t buf_out_data;
  byte_t pins_out, next_pins_out;

  assign buf_in_valid = write_pulse && (ADDR_IN == ADDR_DATA_PORT);

  word_buffer #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_write_buffer (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .in_valid_in(buf_in_valid),
    .in_ready_out(WRITE_READY_OUT),
    .in_data_in(DATA_IN),
    .out_valid_out(buf_out_valid),
    .out_ready_in(~input_mode),
    .out_data_out(buf_out_data)
  );

  always_comb
  begin
    next_pins_out = pins_out;
    if (buf_out_valid && !input_mode)
    begin
      next_pins_out = buf_out_data; // R3
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_out <= DATA_RESET; // R16
    end
    else
    begin
      pins_out <= next_pins_out;
    end
  end

  assign PRINTER_DATA_PINS_OUT = pins_out;

  // =========================================================
  // acknowledge interrupt
  logic ack_q, next_ack_q;
  logic irq_clear, next_irq_clear;
  logic ack_fall, status_read;

  assign ack_fall = ack_q & ~ACK_N_IN;
  assign status_read = read_end && (rd_addr == ADDR_SELECT_STATUS);

  always_comb
  begin
    next_ack_q = ACK_N_IN;
    next_irq_clear = irq_clear;
    // a new acknowledge in the same cycle as the clearing read wins
    if (ack_fall)
    begin
      next_irq_clear = 1'b0; // R6
    end
    else if (status_read)
    begin
      next_irq_clear = 1'b1; // R7
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b1;
      irq_clear <= 1'b1;
    end
    else
    begin
      ack_q <= next_ack_q;
      irq_clear <= next_irq_clear;
    end
  end

  assign PRINTER_IRQ_OE_OUT = ctrl[CTRL_IRQ_ENABLE] & ~irq_clear; // R17
  assign PRINTER_IRQ_OUT = 1'b1;

  // =========================================================
  // read data
  byte_t status_value, command_value, read_mux;
  byte_t read_data, next_read_data;

  always_comb
  begin
    status_value = {~BUSY_IN, ACK_N_IN, PAPER_EMPTY_IN, PRINTER_SELECTED_IN, // R8 R9
                    ERROR_N_IN, irq_clear, STATUS_LOW_ONES}; // R10
    command_value = {COMMAND_HIGH_ONES, ctrl[CTRL_IRQ_ENABLE], ~SELECT_IN_N_OUT, // R11
                     INIT_OUT, ~AUTO_LINEFEED_N_OUT, ~STROBE_N_OUT}; // R12
    unique case (ADDR_IN) // R15
      ADDR_DATA_PORT: read_mux = input_mode ? PRINTER_DATA_PINS_IN : pins_out; // R4
      ADDR_SELECT_STATUS: read_mux = status_value;
      ADDR_CONTROL_COMMAND: read_mux = command_value;
      default: read_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_read_data = read_data;
    if (!RD_N_IN)
    begin
      next_read_data = read_mux;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_data <= 8'h00;
    end
    else
    begin
      read_data <= next_read_data;
    end
  end

  assign DATA_OUT = read_data;
  assign DATA_OE_OUT = ~rd_n_q & ~RD_N_IN;

  // =========================================================
  // checks
  a_select_code_input: assert property ( // R1
    (write_pulse && ADDR_IN == ADDR_SELECT_STATUS && DATA_IN == INPUT_SELECT_CODE
     && !DIRECTION_MODE_PIN_IN) ##1 !DIRECTION_MODE_PIN_IN |-> !PRINTER_DATA_PINS_OE_OUT)
    else $error("select code did not turn pins to input");

  a_select_other_output: assert property ( // R1
    (write_pulse && ADDR_IN == ADDR_SELECT_STATUS && DATA_IN != INPUT_SELECT_CODE
     && !DIRECTION_MODE_PIN_IN) ##1 !DIRECTION_MODE_PIN_IN |-> PRINTER_DATA_PINS_OE_OUT)
    else $error("other select value did not keep pins output");

  a_control_direction: assert property ( // R2
    (write_pulse && ADDR_IN == ADDR_CONTROL_COMMAND && DIRECTION_MODE_PIN_IN)
    ##1 DIRECTION_MODE_PIN_IN |-> PRINTER_DATA_PINS_OE_OUT == !$past(DATA_IN[CTRL_DIRECTION]))
    else $error("control bit 5 did not steer direction");

  a_write_to_pins: assert property ( // R3
    (buf_in_valid && !buf_out_valid && !input_mode) ##1 !input_mode
    |=> PRINTER_DATA_PINS_OUT == $past(DATA_IN, 2))
    else $error("written byte not on data pins");

  a_read_pins: assert property ( // R4
    (!RD_N_IN && ADDR_IN == ADDR_DATA_PORT && input_mode)
    |=> DATA_OUT == $past(PRINTER_DATA_PINS_IN))
    else $error("data port read did not return pins");

  a_ack_pending: assert property ( // R6
    (ack_q && !ACK_N_IN) |=> !irq_clear ##1 (!irq_clear || $past(status_read)))
    else $error("acknowledge edge did not mark pending");

  a_status_clears: assert property ( // R7
    (status_read && !ack_fall) |=> irq_clear && !PRINTER_IRQ_OE_OUT)
    else $error("status read did not clear pending");

  a_status_bits: assert property ( // R8
    (!RD_N_IN && ADDR_IN == ADDR_SELECT_STATUS)
    |=> DATA_OUT[STAT_ACK:STAT_ERROR] == $past({ACK_N_IN, PAPER_EMPTY_IN,
                                                PRINTER_SELECTED_IN, ERROR_N_IN})
        && DATA_OUT[1:0] == 2'h3 && DATA_OUT[STAT_NOT_BUSY] == !$past(BUSY_IN)) // R9 R10
    else $error("status bits wrong");

  a_command_bits: assert property ( // R11
    (!RD_N_IN && ADDR_IN == ADDR_CONTROL_COMMAND)
    |=> DATA_OUT[7:5] == 3'h7 && DATA_OUT[4:0] == $past(ctrl[4:0])) // R12
    else $error("command readback wrong");

  a_control_pins: assert property ( // R13
    (write_pulse && ADDR_IN == ADDR_CONTROL_COMMAND)
    |=> STROBE_N_OUT == !$past(DATA_IN[0]) && INIT_OUT == $past(DATA_IN[2])
        && AUTO_LINEFEED_N_OUT == !$past(DATA_IN[1])
        && SELECT_IN_N_OUT == !$past(DATA_IN[3]))
    else $error("control write did not drive pins");

  a_irq_drive: assert property ( // R17
    $rose(PRINTER_IRQ_OE_OUT) |-> $past(ack_fall || write_pulse) && PRINTER_IRQ_OUT)
    else $error("interrupt drive without cause");

  a_irq_follow_ack: assert property ( // R17
    (ack_fall && ctrl[CTRL_IRQ_ENABLE] && !write_pulse) |=> PRINTER_IRQ_OE_OUT && !irq_clear)
    else $error("enabled pending interrupt not driven");

  a_irq_masked: assert property ( // R14
    (write_pulse && ADDR_IN == ADDR_CONTROL_COMMAND && !DATA_IN[CTRL_IRQ_ENABLE])
    |=> !PRINTER_IRQ_OE_OUT)
    else $error("disabled interrupt still driven");

  a_reset_state: assert property ( // R16
    $rose(rst_n) |-> PRINTER_DATA_PINS_OE_OUT && PRINTER_DATA_PINS_OUT == DATA_RESET
                     && STROBE_N_OUT && !PRINTER_IRQ_OE_OUT) // R5
    else $error("reset did not leave pins in output mode");
endmodule

// ### test/printer_model.sv
/*
  Behavioural printer on the far side of the port: resolves the data
  pins, answers each strobe that arrives while idle with busy and an acknowledge pulse.
  Assumes the port's outputs are synchronous to clk_in.
*/
module printer_model (
  input wire logic clk_in,
  input wire logic strobe_n_in,
  input wire logic [7:0] pins_out_in,
  input wire logic pins_oe_in,
  input wire logic [7:0] peer_data_in,
  input wire logic [7:0] delay_in,
  input wire logic busy_hold_in,
  output logic [7:0] pins_level_out,
  output logic ack_n_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_strobe_n = 1'b1;
  logic [8:0] count = 9'h000;
  // =========================================
  // pin resolution
  // the printer drives the data lines only while the port has released them
  assign pins_level_out = pins_oe_in ? pins_out_in : peer_data_in;
  assign busy_out = busy_hold_in | (count != 9'h000);
  // =========================================
  // strobe answer
  // delay_in lets the bench choose a prompt or a slow printer
  always @(posedge clk_in)
  begin
    last_strobe_n <= strobe_n_in;
    if (last_strobe_n && !strobe_n_in && count == 9'h000)
      count <= {1'b0, delay_in} + 9'h004;
    else if (count != 9'h000)
      count <= count - 9'h001;
    ack_n_out <= !(count == 9'h003 || count == 9'h002);
  end
endmodule

// ### test/printer_port_tb.sv
/*
  Self-checking bench for the printer port: register tasks, a printer
  model on the cable side, tests as sequences of register accesses.
  Assumes the port's hand-over timing for strobes and reset release.
*/
module printer_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import printer_port_pkg::*;
  logic clk = 1'b0;
  logic resetn, wr_n, rd_n, dir_mode, doe, wready, pins_oe, strobe_n;
  logic autolf_n, init, selin_n, err_n, sel, paper_empty, ack_n, busy;
  logic irq, irq_oe, hold;
  addr_t addr;
  byte_t din, dout, pins_in, pins_out, peer_data, delay, rdata;
  byte_t vals [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'hDF};
  int miscompares = 0;
  int samples_checked = 0;
  // =========================================
  // clock, model and port
  initial forever #2.5 clk = ~clk;
  printer_model model_u (.clk_in(clk), .strobe_n_in(strobe_n), .pins_out_in(pins_out),
    .pins_oe_in(pins_oe), .peer_data_in(peer_data), .delay_in(delay),
    .busy_hold_in(hold), .pins_level_out(pins_in), .ack_n_out(ack_n), .busy_out(busy));
  printer_port dut_u (.CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr), .WR_N_IN(wr_n),
    .RD_N_IN(rd_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(doe),
    .WRITE_READY_OUT(wready), .DIRECTION_MODE_PIN_IN(dir_mode),
    .PRINTER_DATA_PINS_IN(pins_in), .PRINTER_DATA_PINS_OUT(pins_out),
    .PRINTER_DATA_PINS_OE_OUT(pins_oe), .STROBE_N_OUT(strobe_n),
    .AUTO_LINEFEED_N_OUT(autolf_n), .INIT_OUT(init), .SELECT_IN_N_OUT(selin_n),
    .ERROR_N_IN(err_n), .PRINTER_SELECTED_IN(sel), .PAPER_EMPTY_IN(paper_empty),
    .ACK_N_IN(ack_n), .BUSY_IN(busy), .PRINTER_IRQ_OUT(irq), .PRINTER_IRQ_OE_OUT(irq_oe));
  // =========================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe goes high again for two full cycles so back-to-back writes are both seen
  task automatic wr(input addr_t a, input byte_t d);
    addr = a;
    din = d;
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input addr_t a, output byte_t d);
    addr = a;
    rd_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(doe), 8'h01);
    d = dout;
    rd_n = 1'b1;
    @(negedge clk);
  endtask
  task automatic wait_ack;
    int n;
    n = 0;
    while (ack_n !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    while (ack_n !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // =========================================
  // watchdog
  initial
  begin
    #(20000 * 5);
    miscompares++;
    $display("watchdog expired");
    close_out();
  end
  // =========================================
  // tests
  initial
  begin
    {addr, din, dir_mode, hold, delay} = '0;
    {wr_n, rd_n, err_n, sel, paper_empty} = 5'h1F;
    peer_data = 8'h3C;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(pins_oe), 8'h01);
    chk(pins_out, 8'h00);
    chk(8'({strobe_n, irq_oe}), 8'h02);
    rd(2'h2, rdata);
    chk(rdata, 8'hE0);
    rd(2'h3, rdata);
    chk(rdata, 8'h00);
    $display("test reset done");
    foreach (vals[i])
    begin
      wr(2'h2, vals[i]);
      chk(8'({selin_n, init, autolf_n, strobe_n}), 8'(vals[i][3:0] ^ 4'hB));
      rd(2'h2, rdata);
      chk(rdata, {3'h7, vals[i][4:0]});
    end
    chk(8'(pins_oe), 8'h01);
    wr(2'h3, 8'h00);
    rd(2'h2, rdata);
    chk(rdata, 8'hFF);
    wr(2'h2, 8'h00);
    $display("test control done");
    wr(2'h0, 8'h5A);
    repeat (3) @(negedge clk);
    chk(pins_out, 8'h5A);
    rd(2'h0, rdata);
    chk(rdata, 8'h5A);
    wr(2'h1, 8'hAB);
    chk(8'(pins_oe), 8'h01);
    wr(2'h1, 8'hAA);
    chk(8'(pins_oe), 8'h00);
    rd(2'h0, rdata);
    chk(rdata, 8'h3C);
    // while the pins are inputs, a third word finds the buffer full and is lost
    wr(2'h0, 8'h11);
    wr(2'h0, 8'h22);
    chk(8'(wready), 8'h00);
    wr(2'h0, 8'h33);
    wr(2'h1, 8'h00);
    repeat (4) @(negedge clk);
    chk(pins_out, 8'h22);
    chk(8'(wready), 8'h01);
    $display("test data done");
    dir_mode = 1'b1;
    wr(2'h1, 8'hAA);
    chk(8'(pins_oe), 8'h01);
    wr(2'h2, 8'h20);
    chk(8'(pins_oe), 8'h00);
    wr(2'h2, 8'hC0);
    chk(8'(pins_oe), 8'h01);
    dir_mode = 1'b0;
    @(negedge clk);
    chk(8'(pins_oe), 8'h00);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'h00);
    $display("test direction done");
    rd(2'h1, rdata);
    for (int i = 0; i < 16; i++)
    begin
      {hold, paper_empty, sel, err_n} = 4'(i);
      @(negedge clk);
      rd(2'h1, rdata);
      chk(rdata, {~hold, 1'b1, paper_empty, sel, err_n, 3'h7});
    end
    {hold, paper_empty, sel, err_n} = 4'h3;
    $display("test status done");
    wr(2'h2, 8'h11);
    wait_ack();
    wr(2'h2, 8'h10);
    chk(8'({irq, irq_oe}), 8'h03);
    rd(2'h1, rdata);
    chk(8'(rdata[2]), 8'h00);
    chk(8'(irq_oe), 8'h00);
    rd(2'h1, rdata);
    chk(8'(rdata[2]), 8'h01);
    delay = 8'd20;
    wr(2'h2, 8'h01);
    wait_ack();
    chk(8'(irq_oe), 8'h00);
    rd(2'h1, rdata);
    chk(8'(rdata[2]), 8'h00);
    $display("test interrupt done");
    close_out();
  end
endmodule
